// ===== hw/bst_pkg.sv
/*
  Package for the boundary scan test access port: instruction codes,
  widths, pin counts, identification fields and link timing.
  Assumes a single system clock that oversamples the test clock.
*/
package bst_pkg;
  // Instruction register width and codes
  localparam int IR_W = 3;
  localparam logic [2:0] INS_EXTEST = 3'h0;
  localparam logic [2:0] INS_INTEST = 3'h1;
  localparam logic [2:0] INS_SAMPLE = 3'h2;
  localparam logic [2:0] INS_IDCODE = 3'h3;
  localparam logic [2:0] INS_BYPASS = 3'h7;
  localparam logic [2:0] IR_DEFAULT = INS_INTEST;
  localparam logic [2:0] IR_CAPTURE = 3'h1;
  // Identification word layout
  localparam int ID_W = 32;
  localparam int ID_VER_LSB = 28;
  localparam int ID_PART_LSB = 12;
  localparam int ID_MAKER_LSB = 1;
  // Pin counts per type in chain order
  localparam int N_IN = 30;
  localparam int N_OUT = 18;
  localparam int N_IO = 22;
  localparam int N_POS = 70;
  // Clock rates
  localparam int SYS_CLK_KHZ = 125000;
  localparam int TCK_MAX_KHZ = 6250;
  localparam int OVERSAMPLE = SYS_CLK_KHZ / TCK_MAX_KHZ;
  // TAP controller states
  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR, ST_EX2_DR, ST_UPD_DR,
    ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
  } bst_state_t;
endpackage : bst_pkg

// ===== hw/bst_tap.sv
/*
  Boundary scan test access port with instruction, bypass, identification
  and boundary registers. The test clock is oversampled by the system
  clock; tck, tms and tdi pass two flip-flops before use. Pins are ordered
  in chain positions with inputs, outputs and two-way pins each packed in
  a vector, chain order given by the per-position type table below.
*/
// Contract
// - TAP state machine follows 1149.1 on TMS
// - 3-bit decode; unlisted codes mean bypass
// - External test drives pins at update, falling
// - External test captures input pins at capture
// - Internal test feeds core inputs at update
// - Internal test captures core outputs at capture
// - Instruction register default is internal test
// - Test-logic-reset loads identification code
// - Sample/preload never disturbs system pins
// - 32-bit identification word with three fields
// - Identification word bit zero reads one
// - Bypass delays TDI by one stage
// - Cells: one input, two output, three bidir
// - Test clock up to 6.25 MHz
`timescale 1ns/1ns
`default_nettype none
module bst_tap #(
  parameter logic [3:0] ID_VERSION = 4'h5, // Arbitrary value
  parameter logic [15:0] ID_PART = 16'h1234, // Arbitrary value
  parameter logic [10:0] ID_MAKER = 11'h2a5 // Arbitrary value
) (
  input wire logic clock, // System clock
  input wire logic arst_n, // Asynchronous reset, active low
  input wire logic clk_en, // Freezes all state when low
  input wire logic tck, // Test clock pin
  input wire logic tms, // Test mode select pin
  input wire logic tdi, // Test data in pin
  output logic tdo_o, // Test data out value
  output logic tdo_oe, // Test data out enable
  input wire logic [bst_pkg::N_IN-1:0] pin_in, // Input pin levels
  output logic [bst_pkg::N_IN-1:0] core_in, // Inputs seen by the core
  input wire logic [bst_pkg::N_OUT-1:0] core_out, // Core output values
  input wire logic [bst_pkg::N_OUT-1:0] core_out_en, // Core output enables
  output logic [bst_pkg::N_OUT-1:0] pin_out, // Output pin values
  output logic [bst_pkg::N_OUT-1:0] pin_out_en, // Output pin enables
  input wire logic [bst_pkg::N_IO-1:0] io_in, // Two-way pin levels
  output logic [bst_pkg::N_IO-1:0] io_core_in, // Two-way levels to core
  input wire logic [bst_pkg::N_IO-1:0] io_core_out, // Core two-way values
  input wire logic [bst_pkg::N_IO-1:0] io_core_en, // Core two-way enables
  output logic [bst_pkg::N_IO-1:0] io_out, // Two-way pin values
  output logic [bst_pkg::N_IO-1:0] io_oe, // Two-way pin enables
  output logic [3:0] tap_state // Controller state for observation
);
  // Cell totals per pin type
  localparam int NB = bst_pkg::N_IN + 2 * bst_pkg::N_OUT + 3 * bst_pkg::N_IO;
  // Position type: 0 input, 1 output, 2 two-way; first entry is next to TDI
  // Rows of ten positions, the last row ends at position 70 next to TDO
  localparam logic [139:0] POS_TYPE = {
    2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h0,
    2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2,
    2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h1, 2'h0, 2'h2, 2'h2,
    2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h0, 2'h0,
    2'h1, 2'h1, 2'h1, 2'h1, 2'h0, 2'h0, 2'h1, 2'h1, 2'h0, 2'h0,
    2'h0, 2'h0, 2'h1, 2'h1, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0,
    2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h0, 2'h0};

  // Type of one chain position, counted from the TDI end
  function automatic logic [1:0] pos_type(input int p);
    pos_type = POS_TYPE[139 - 2 * p -: 2];
  endfunction : pos_type

  // Positions of one type; used by the elaboration checks below
  function automatic int count_type(input logic [1:0] t);
    count_type = 0;
    for (int p = 0; p < bst_pkg::N_POS; p++) begin
      if (pos_type(p) == t) count_type = count_type + 1;
    end
  endfunction : count_type

  // Refuse a clock too slow to see both test clock edges, or a table that misfits the pins
  if (bst_pkg::OVERSAMPLE < 4) begin : g_bad_rate
    $error("System clock too slow for the test clock");
  end
  if ($bits(POS_TYPE) != 2 * bst_pkg::N_POS) begin : g_bad_table
    $error("Type table length does not match the chain length");
  end
  if (count_type(2'h0) != bst_pkg::N_IN) begin : g_bad_in
    $error("Input pin count does not match the type table");
  end
  if (count_type(2'h1) != bst_pkg::N_OUT) begin : g_bad_out
    $error("Output pin count does not match the type table");
  end
  if (count_type(2'h2) != bst_pkg::N_IO) begin : g_bad_io
    $error("Two-way pin count does not match the type table");
  end
  if (bst_pkg::N_IN + bst_pkg::N_OUT + bst_pkg::N_IO != bst_pkg::N_POS) begin : g_bad_pos
    $error("Pin counts do not add up to the chain length");
  end

  // Pin synchronisers, two stages each
  logic [2:0] sync1_ff, sync2_ff;
  logic tck_d_ff;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sync1_ff <= 3'h0;
      sync2_ff <= 3'h0;
      tck_d_ff <= 1'b0;
    end else if (clk_en) begin
      sync1_ff <= {tck, tms, tdi};
      sync2_ff <= sync1_ff;
      tck_d_ff <= sync2_ff[2];
    end
  end
  wire tck_s = sync2_ff[2];
  wire tms_s = sync2_ff[1];
  wire tdi_s = sync2_ff[0];
  wire tck_rise = clk_en & tck_s & ~tck_d_ff;
  wire tck_fall = clk_en & ~tck_s & tck_d_ff;

  // Controller next state
  bst_pkg::bst_state_t state_ff, nxt_state;
  always_comb begin
    case (state_ff)
      bst_pkg::ST_RESET: nxt_state = tms_s ? bst_pkg::ST_RESET : bst_pkg::ST_IDLE;
      bst_pkg::ST_IDLE: nxt_state = tms_s ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
      bst_pkg::ST_SEL_DR: nxt_state = tms_s ? bst_pkg::ST_SEL_IR : bst_pkg::ST_CAP_DR;
      bst_pkg::ST_CAP_DR: nxt_state = tms_s ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SH_DR;
      bst_pkg::ST_SH_DR: nxt_state = tms_s ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SH_DR;
      bst_pkg::ST_EX1_DR: nxt_state = tms_s ? bst_pkg::ST_UPD_DR : bst_pkg::ST_PAU_DR;
      bst_pkg::ST_PAU_DR: nxt_state = tms_s ? bst_pkg::ST_EX2_DR : bst_pkg::ST_PAU_DR;
      bst_pkg::ST_EX2_DR: nxt_state = tms_s ? bst_pkg::ST_UPD_DR : bst_pkg::ST_SH_DR;
      bst_pkg::ST_UPD_DR: nxt_state = tms_s ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
      bst_pkg::ST_SEL_IR: nxt_state = tms_s ? bst_pkg::ST_RESET : bst_pkg::ST_CAP_IR;
      bst_pkg::ST_CAP_IR: nxt_state = tms_s ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SH_IR;
      bst_pkg::ST_SH_IR: nxt_state = tms_s ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SH_IR;
      bst_pkg::ST_EX1_IR: nxt_state = tms_s ? bst_pkg::ST_UPD_IR : bst_pkg::ST_PAU_IR;
      bst_pkg::ST_PAU_IR: nxt_state = tms_s ? bst_pkg::ST_EX2_IR : bst_pkg::ST_PAU_IR;
      bst_pkg::ST_EX2_IR: nxt_state = tms_s ? bst_pkg::ST_UPD_IR : bst_pkg::ST_SH_IR;
      bst_pkg::ST_UPD_IR: nxt_state = tms_s ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
      default: nxt_state = bst_pkg::ST_RESET;
    endcase
  end

  // State moves on each rising test clock edge
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) state_ff <= bst_pkg::ST_RESET;
    else if (tck_rise) state_ff <= nxt_state;
  end
  assign tap_state = state_ff;

  // State decodes
  wire in_reset = (state_ff == bst_pkg::ST_RESET);
  wire in_cap_dr = (state_ff == bst_pkg::ST_CAP_DR);
  wire in_sh_dr = (state_ff == bst_pkg::ST_SH_DR);
  wire in_upd_dr = (state_ff == bst_pkg::ST_UPD_DR);
  wire in_cap_ir = (state_ff == bst_pkg::ST_CAP_IR);
  wire in_sh_ir = (state_ff == bst_pkg::ST_SH_IR);
  wire in_upd_ir = (state_ff == bst_pkg::ST_UPD_IR);

  // Instruction shift and active registers
  logic [2:0] ir_sh_ff, ir_ff;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ir_sh_ff <= bst_pkg::IR_DEFAULT;
      ir_ff <= bst_pkg::IR_DEFAULT;
    end else if (tck_rise && in_cap_ir) begin
      ir_sh_ff <= bst_pkg::IR_CAPTURE;
    end else if (tck_rise && in_sh_ir) begin
      ir_sh_ff <= {tdi_s, ir_sh_ff[2:1]};
    end else if (tck_fall && in_reset) begin
      ir_ff <= bst_pkg::INS_IDCODE;
    end else if (tck_fall && in_upd_ir) begin
      ir_ff <= ir_sh_ff;
    end
  end

  // Instruction decode; anything unlisted falls to bypass
  wire is_extest = (ir_ff == bst_pkg::INS_EXTEST);
  wire is_intest = (ir_ff == bst_pkg::INS_INTEST);
  wire is_sample = (ir_ff == bst_pkg::INS_SAMPLE);
  wire is_idcode = (ir_ff == bst_pkg::INS_IDCODE);
  wire is_bsr = is_extest | is_intest | is_sample;
  wire is_bypass = ~is_bsr & ~is_idcode;

  // Identification word with bit zero fixed high
  wire [31:0] id_word = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};

  // Gather chain capture values; position 70 sits next to TDO
  logic [NB-1:0] cap_vec;
  logic [NB-1:0] upd_ff;
  always_comb begin
    int b, ni, no, nio, p;
    logic [1:0] t;
    b = NB;
    ni = 0;
    no = 0;
    nio = 0;
    p = 0;
    t = 2'h0;
    cap_vec = '0;
    for (p = 0; p < bst_pkg::N_POS; p++) begin
      t = pos_type(p);
      if (t == 2'h0) begin
        b = b - 1;
        cap_vec[b] = is_intest ? core_in[ni] : pin_in[ni];
        ni = ni + 1;
      end else if (t == 2'h1) begin
        b = b - 2;
        cap_vec[b +: 2] = is_intest ? {core_out[no], core_out_en[no]}
                                    : {pin_out[no], pin_out_en[no]};
        no = no + 1;
      end else begin
        b = b - 3;
        cap_vec[b +: 3] = is_intest ? {io_core_in[nio], io_core_out[nio], io_core_en[nio]}
                                    : {io_in[nio], io_out[nio], io_oe[nio]};
        nio = nio + 1;
      end
    end
  end

  // Data registers: bypass, identification, boundary shift
  logic byp_ff;
  logic [31:0] id_sh_ff;
  logic [NB-1:0] bsr_sh_ff;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      byp_ff <= 1'b0;
      id_sh_ff <= 32'h0;
      bsr_sh_ff <= '0;
    end else if (tck_rise && in_cap_dr) begin
      byp_ff <= 1'b0;
      id_sh_ff <= id_word;
      if (is_bsr) bsr_sh_ff <= cap_vec;
    end else if (tck_rise && in_sh_dr) begin
      byp_ff <= tdi_s;
      id_sh_ff <= {tdi_s, id_sh_ff[31:1]};
      if (is_bsr) bsr_sh_ff <= {tdi_s, bsr_sh_ff[NB-1:1]};
    end
  end

  // Update latch loads on the falling edge in update-DR
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) upd_ff <= '0;
    else if (tck_fall && in_upd_dr && is_bsr) upd_ff <= bsr_sh_ff;
  end

  // Scatter update latch to pins and core
  logic [bst_pkg::N_IN-1:0] u_in;
  logic [bst_pkg::N_OUT-1:0] u_out, u_oen;
  logic [bst_pkg::N_IO-1:0] u_ioi, u_ioo, u_ioe;
  always_comb begin
    int b, ni, no, nio, p;
    logic [1:0] t;
    b = NB;
    ni = 0;
    no = 0;
    nio = 0;
    u_in = '0;
    u_out = '0;
    u_oen = '0;
    u_ioi = '0;
    u_ioo = '0;
    u_ioe = '0;
    p = 0;
    t = 2'h0;
    for (p = 0; p < bst_pkg::N_POS; p++) begin
      t = pos_type(p);
      if (t == 2'h0) begin
        b = b - 1;
        u_in[ni] = upd_ff[b];
        ni = ni + 1;
      end else if (t == 2'h1) begin
        b = b - 2;
        {u_out[no], u_oen[no]} = upd_ff[b +: 2];
        no = no + 1;
      end else begin
        b = b - 3;
        {u_ioi[nio], u_ioo[nio], u_ioe[nio]} = upd_ff[b +: 3];
        nio = nio + 1;
      end
    end
  end

  // Pin and core muxing; sample leaves the system path alone
  assign pin_out = is_extest ? u_out : core_out;
  assign pin_out_en = is_extest ? u_oen : core_out_en;
  assign io_out = is_extest ? u_ioo : io_core_out;
  assign io_oe = is_extest ? u_ioe : io_core_en;
  assign core_in = is_intest ? u_in : pin_in;
  assign io_core_in = is_intest ? u_ioi : io_in;

  // Serial output selection
  wire dr_bit = is_bsr ? bsr_sh_ff[0] : (is_idcode ? id_sh_ff[0] : byp_ff);
  wire tdo_nxt = in_sh_ir ? ir_sh_ff[0] : dr_bit;

  // Output changes on falling edge, enabled only while shifting
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tdo_o <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      tdo_o <= tdo_nxt;
      tdo_oe <= in_sh_ir | in_sh_dr;
    end
  end
endmodule : bst_tap
`default_nettype wire

// ===== sim/bst_tap_sva.sv
/* Checker for the boundary scan port: controller steps, data-out window, pin hold.
   Assumes clk_en stays high and bst_pkg is compiled first. */
`timescale 1ns/1ns
`default_nettype none
module bst_tap_sva (
  input wire logic clock, // System clock
  input wire logic arst_n, // Reset, active low
  input wire logic tck, // Test clock pin
  input wire logic tdo_oe, // Data-out enable
  input wire logic [3:0] tap_state, // Controller state
  input wire logic [bst_pkg::N_IN-1:0] pin_in, // Input pins
  input wire logic [bst_pkg::N_IN-1:0] core_in, // Core inputs
  input wire logic [bst_pkg::N_OUT-1:0] core_out, // Core outputs
  input wire logic [bst_pkg::N_OUT-1:0] pin_out // Output pins
);
  // Successor for a mode bit of 0 and of 1
  localparam logic [3:0] SUC0 [16] = '{4'h1, 4'h1, 4'h3, 4'h4, 4'h4, 4'h6, 4'h6, 4'h4,
    4'h1, 4'ha, 4'hb, 4'hb, 4'hd, 4'hd, 4'hb, 4'h1};
  localparam logic [3:0] SUC1 [16] = '{4'h0, 4'h2, 4'h9, 4'h5, 4'h5, 4'h8, 4'h7, 4'h8,
    4'h2, 4'h0, 4'hc, 4'hc, 4'hf, 4'he, 4'hf, 4'h2};
  logic [3:0] prv_ff;
  logic [2:0] tsy_ff;
  logic [1:0] nfall_ff;
  wire logic tck_fell = tsy_ff[2] & ~tsy_ff[1];
  // Last state, synced test clock, falls seen while in reset state
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      prv_ff <= 4'h0;
      tsy_ff <= 3'h0;
      nfall_ff <= 2'h0;
    end else begin
      prv_ff <= tap_state;
      tsy_ff <= {tsy_ff[1:0], tck};
      nfall_ff <= (tap_state != 4'h0) ? 2'h0 : nfall_ff + {1'b0, tck_fell & (nfall_ff != 2'h3)};
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  property p_legal; tap_state != prv_ff |-> tap_state == SUC0[prv_ff] || tap_state == SUC1[prv_ff]; endproperty
  a_legal: assert property (p_legal) else $error("illegal controller step");
  property p_rst; $rose(arst_n) |-> tap_state == 4'h0 && !tdo_oe; endproperty
  a_rst: assert property (p_rst) else $error("state after reset");
  property p_st_edge; $changed(tap_state) |-> $past(tck, 2); endproperty
  a_st_edge: assert property (p_st_edge) else $error("state moved off rising test clock");
  property p_oe_win; tdo_oe |-> tap_state inside {4'h4, 4'h5, 4'hb, 4'hc}; endproperty
  a_oe_win: assert property (p_oe_win) else $error("data out driven outside shift");
  property p_oe_fall; $changed(tdo_oe) |-> !$past(tck, 2); endproperty
  a_oe_fall: assert property (p_oe_fall) else $error("data out enable off falling edge");
  property p_pin_hold; $changed(pin_out) && $stable(core_out) |-> tap_state inside {4'h0, 4'h8, 4'hf}; endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("output pins moved outside update");
  property p_core_hold; $changed(core_in) && $stable(pin_in) |-> tap_state inside {4'h0, 4'h8, 4'hf}; endproperty
  a_core_hold: assert property (p_core_hold) else $error("core inputs moved outside update");
  property p_tlr; nfall_ff == 2'h2 |-> core_in == pin_in && pin_out == core_out; endproperty
  a_tlr: assert property (p_tlr) else $error("reset state left a test mode on");
  c_shift_dr: cover property (tap_state == 4'h4 && tdo_oe);
  c_upd_ir: cover property (tap_state == 4'hf);
  c_tlr: cover property (nfall_ff == 2'h2);
endmodule : bst_tap_sva
bind bst_tap bst_tap_sva u_sva (.clock(clock), .arst_n(arst_n), .tck(tck), .tdo_oe(tdo_oe),
  .tap_state(tap_state), .pin_in(pin_in), .core_in(core_in), .core_out(core_out), .pin_out(pin_out));
`default_nettype wire

// ===== sim/bst_tester.sv
/* Tester model: drives test clock, mode and data pins, samples data out.
   Assumes a 125 MHz system clock; test clock runs at 160 ns. */
`timescale 1ns/1ns
`default_nettype none
module bst_tester (
  input wire logic clock, // System clock
  input wire logic tdo, // Resolved data-out wire
  output logic tck, // Test clock, low between frames
  output logic tms, // Mode select
  output logic tdi // Data in
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // One test clock; data out is taken just before the rise
  task automatic step(input logic m, input logic d, output logic q);
    @(negedge clock) tms = m;
    tdi = d;
    repeat (9) @(negedge clock);
    q = tdo;
    tck = 1'b1;
    repeat (10) @(negedge clock);
    tck = 1'b0;
    tdi = ~d; // Stale data is not left on the line
  endtask : step
endmodule : bst_tester
`default_nettype wire

// ===== sim/tb_top.sv
/* Bench for the boundary scan port: instruction table, then preload, pin and reset tests.
   Assumes the tester model and the checker are compiled beside it. */
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_mismatch++; $display("BAD %0t got %0h exp %0h", $time, a, e); end end
module tb_top;
  typedef struct {logic [2:0] code; int len;} bst_row_t;
  localparam logic [3:0] ID_V = 4'h9; // Arbitrary value
  localparam logic [15:0] ID_P = 16'h6b2c; // Arbitrary value
  localparam logic [10:0] ID_M = 11'h155; // Arbitrary value
  localparam int BSR_LEN = 30 + 2 * 18 + 3 * 22; // Cells of inputs, outputs, two-way pins
  localparam logic [159:0] PAT = {5{32'hc3a50f96}};
  bst_row_t rows [8] = '{'{3'h0, BSR_LEN}, '{3'h1, BSR_LEN}, '{3'h2, BSR_LEN}, '{3'h3, 32},
    '{3'h4, 1}, '{3'h5, 1}, '{3'h6, 1}, '{3'h7, 1}};
  int n_mismatch = 0;
  int total_checks = 0;
  logic clock = 1'b0;
  logic arst_n, clk_en, tck, tms, tdi, tdo_o, tdo_oe;
  logic [3:0] tap_state;
  logic [bst_pkg::N_IN-1:0] pin_in, core_in;
  logic [bst_pkg::N_OUT-1:0] core_out, core_out_en, pin_out, pin_out_en;
  logic [bst_pkg::N_IO-1:0] io_in, io_core_in, io_core_out, io_core_en, io_out, io_oe;
  wire logic tdo_w = tdo_oe ? tdo_o : 1'bz;
  always #4 clock = ~clock;
  bst_tap #(.ID_VERSION(ID_V), .ID_PART(ID_P), .ID_MAKER(ID_M)) DUT (.clock, .arst_n, .clk_en, .tck, .tms,
    .tdi, .tdo_o, .tdo_oe, .pin_in, .core_in, .core_out, .core_out_en, .pin_out, .pin_out_en, .io_in,
    .io_core_in, .io_core_out, .io_core_en, .io_out, .io_oe, .tap_state);
  bst_tester u_tst (.clock(clock), .tdo(tdo_w), .tck(tck), .tms(tms), .tdi(tdi));
  // Mode bits taken LSB first
  task automatic walk(input logic [7:0] ms, input int n);
    logic q;
    for (int i = 0; i < n; i++) u_tst.step(ms[i], 1'b0, q);
  endtask : walk
  task automatic ir(input logic [2:0] c, output logic [2:0] o);
    logic q;
    walk(8'h03, 4);
    for (int i = 0; i < 3; i++) begin
      u_tst.step(i == 2, c[i], q);
      o[i] = q;
    end
    walk(8'h01, 2);
  endtask : ir
  task automatic dr(input logic [159:0] d, input int n, output logic [159:0] o);
    logic q;
    o = '0;
    walk(8'h01, 3);
    for (int i = 0; i < n; i++) begin
      u_tst.step(i == n - 1, d[i], q);
      o[i] = q;
    end
    walk(8'h01, 2);
  endtask : dr
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude
  initial begin
    #600000; // About twice the expected run time
    n_mismatch++;
    conclude();
  end
  initial begin
    logic [2:0] o3;
    logic [159:0] o;
    {arst_n, clk_en, core_out, core_out_en, io_core_out, io_core_en} = '0;
    clk_en = 1'b1;
    pin_in = '1;
    io_in = '1;
    repeat (4) @(negedge clock);
    arst_n = 1'b1;
    repeat (4) @(negedge clock);
    `CHK(tap_state, 4'h0)
    `CHK(tdo_w, 1'bz)
    `CHK(core_in, '0)
    walk(8'h01, 2);
    `CHK(core_in, pin_in)
    dr(PAT, 32, o);
    `CHK(o[31:0], {ID_V, ID_P, ID_M, 1'b1})
    `CHK(o[0], 1'b1)
    foreach (rows[r]) begin
      ir(rows[r].code, o3);
      `CHK(o3, 3'h1)
      dr(PAT, 160, o);
      `CHK(o >> rows[r].len, (PAT << rows[r].len) >> rows[r].len)
      `CHK(tdo_w, 1'bz)
    end
    ir(3'h2, o3);
    dr('1, BSR_LEN, o);
    `CHK(pin_out, core_out)
    ir(3'h0, o3);
    `CHK({pin_out, pin_out_en, io_out, io_oe}, '1)
    dr('0, BSR_LEN, o);
    `CHK(o[0], 1'b1)
    pin_in = '0;
    io_in = '0;
    dr('1, BSR_LEN, o);
    `CHK(o[0], 1'b0)
    `CHK(pin_out, '1)
    ir(3'h1, o3);
    `CHK({core_in, io_core_in}, '1)
    core_out = '1;
    io_core_out = '1;
    dr('0, BSR_LEN, o);
    `CHK(o[3:2], 2'h2)
    `CHK(core_in, '0)
    walk(8'h1f, 5);
    `CHK(tap_state, 4'h0)
    `CHK({core_in, pin_out}, {pin_in, core_out})
    // Reset in mid-shift under external test, then a step with the clock enable low
    walk(8'h00, 1);
    ir(3'h0, o3);
    `CHK(o3, 3'h1)
    walk(8'h01, 3);
    repeat (4) @(negedge clock);
    `CHK(tdo_w, 1'b0)
    `CHK(pin_out, '0)
    pin_in = '1;
    arst_n = 1'b0;
    repeat (4) @(negedge clock);
    arst_n = 1'b1;
    repeat (4) @(negedge clock);
    `CHK(tap_state, 4'h0)
    `CHK(tdo_w, 1'bz)
    `CHK(core_in, '0)
    `CHK(pin_out, core_out)
    walk(8'h01, 2);
    `CHK(core_in, pin_in)
    clk_en = 1'b0;
    walk(8'h01, 1);
    clk_en = 1'b1;
    repeat (4) @(negedge clock);
    `CHK(tap_state, 4'h1)
    conclude();
  end
endmodule : tb_top
`default_nettype wire
